/* tfe_pkg.sv */
// Constants shared by the timer flag and interrupt release block
package tfe_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h01;
    localparam logic [7:0] IDX_TCTRL = 8'h0E;
    localparam logic [7:0] IDX_PRESET = 8'h0F;
    localparam logic [7:0] IDX_ISTAT = 8'h10;
    localparam logic [7:0] IDX_IMASK = 8'h11;
    // Field positions
    localparam int CTRL_IRQ_EN_BIT = 0;
    localparam int CTRL_FLAG_BIT = 2;
    localparam int CTRL_MODE_BIT = 4;
    localparam int CTRL_PIN_BIT = 8;
    localparam int TCTRL_RUN_BIT = 7;
    localparam int ISTAT_EVENT_BIT = 0;
    localparam int ISTAT_RELEASE_BIT = 1;
    localparam int ISTAT_W = 2;
    // Values after reset, and the word transfer size
    localparam logic [7:0] PRESET_RST = 8'h00;
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [ISTAT_W-1:0] IMASK_RST = 2'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Automatic release times of the pin in repeated mode
    localparam int RTN_122US_NS = 122000;
    localparam int RTN_244US_NS = 244000;
    localparam int RTN_7813US_NS = 7813000;
    localparam int RTN_15625US_NS = 15625000;
    localparam int RTN_122US_CYC = RTN_122US_NS / CLK_PERIOD_NS;
    localparam int RTN_244US_CYC = RTN_244US_NS / CLK_PERIOD_NS;
    localparam int RTN_7813US_CYC = RTN_7813US_NS / CLK_PERIOD_NS;
    localparam int RTN_15625US_CYC = RTN_15625US_NS / CLK_PERIOD_NS;
    localparam int RTN_W_DEF = 21;

    typedef enum logic {TFE_LEVEL, TFE_REPEAT} tfe_mode_e;

    function automatic logic [7:0] tfe_reg_idx(input logic [31:0] addr);
        return addr[9:2];
    endfunction

    function automatic logic tfe_reg_hit(input logic [31:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        return (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0) &&
               (idx == IDX_CTRL || idx == IDX_TCTRL || idx == IDX_PRESET ||
                idx == IDX_ISTAT || idx == IDX_IMASK);
    endfunction
endpackage

/* tfe_tmr_if.sv */
// Signals between the control top, the down counter and the release timer
`timescale 1ns/1ps
interface tfe_tmr_if #(
    parameter int RTN_W = 21
);
    logic run;
    logic [1:0] sel;
    logic [7:0] preset;
    logic preset_wr;
    logic [3:0] tick;
    logic [7:0] count;
    logic event_p;
    logic rtn_start;
    logic [RTN_W-1:0] rtn_len;
    logic rtn_busy;
    logic rtn_done;

    modport top (output run, sel, preset, preset_wr, tick, rtn_start,
                 rtn_len, input count, event_p, rtn_busy, rtn_done);
    modport cnt (input run, sel, preset, preset_wr, tick,
                 output count, event_p);
    modport rtn (input rtn_start, rtn_len, output rtn_busy, rtn_done);
endinterface

/* tfe_down_count.sv */
// Tick-driven down counter with reload and event pulse
`timescale 1ns/1ps
module tfe_down_count
    import tfe_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    tfe_tmr_if.cnt bus
);
    logic [7:0] count_ff;
    logic event_ff;
    logic step;

    assign step = bus.run && bus.tick[bus.sel] && (count_ff != 8'h00);
    assign bus.count = count_ff;
    assign bus.event_p = event_ff;

    // Counter runs only while enabled; the flag never touches it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_ff <= PRESET_RST;
        end else if (!bus.run && bus.preset_wr) begin
            count_ff <= bus.preset;
        end else if (step) begin
            count_ff <= (count_ff == 8'h01) ? bus.preset : count_ff - 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_ff <= 1'b0;
        end else begin
            event_ff <= step && (count_ff == 8'h01);
        end
    end
endmodule // tfe_down_count

/* tfe_release_timer.sv */
// Hold timer for the pin in repeated mode
`timescale 1ns/1ps
module tfe_release_timer
    import tfe_pkg::*;
#(
    parameter int RTN_W = 21
)(
    input wire logic hclk,
    input wire logic hresetn,
    tfe_tmr_if.rtn bus
);
    logic [RTN_W-1:0] left_ff;
    logic done_ff;

    assign bus.rtn_busy = (left_ff != '0);
    assign bus.rtn_done = done_ff;

    // A new event restarts the hold time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_ff <= '0;
        end else if (bus.rtn_start) begin
            left_ff <= bus.rtn_len;
        end else if (left_ff != '0) begin
            left_ff <= left_ff - 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= !bus.rtn_start && (left_ff == {{(RTN_W-1){1'b0}}, 1'b1});
        end
    end
endmodule // tfe_release_timer

/* tfe_timer_irq.sv */
// Timer flag, interrupt enable and open-drain pin control on AHB-Lite
`timescale 1ns/1ps
// How it works
// - A timer event sets the flag, which stays set until software clears it.
// - Writing zero to the flag clears it and arms the next detection.
// - Clearing the flag leaves the running countdown untouched.
// - Level mode: flag cleared releases the pin to high impedance.
// - Level mode, still running: next step from 01h (reload to preset) sets flag, pulls pin.
// - Writing one to the flag leaves its stored value unchanged.
// - With interrupt enable one, each event pulls the pin low.
// - With interrupt enable zero, events set the flag but leave the pin released.
// - Clearing interrupt enable while the pin is low releases it.
// - Level mode: enable rising while flag set pulls the pin at once.
// - Mode bit zero selects level mode, one selects repeated mode.
// - Repeated mode holds the pin low for the release time, then frees it.
// - Run enable one counts down; zero stops the countdown.
module tfe_timer_irq
    import tfe_pkg::*;
#(
    parameter int RTN_W = RTN_W_DEF,
    parameter int RTN_SHORT_CYC = RTN_122US_CYC,
    parameter int RTN_TICK_CYC = RTN_244US_CYC,
    parameter int RTN_MID_CYC = RTN_7813US_CYC,
    parameter int RTN_LONG_CYC = RTN_15625US_CYC
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] src_tick,
    input wire logic tirq_pin_i,
    output logic tirq_o,
    output logic tirq_oe_n,
    output logic irq
);
    if (RTN_W < 2 || RTN_W > 31 || RTN_SHORT_CYC < 1 ||
        $clog2(RTN_LONG_CYC + 1) > RTN_W) begin : g_chk
        $error("tfe_timer_irq: release counter too narrow");
    end

    ////////////////////////////////////////////////////////////////////////
    tfe_tmr_if #(.RTN_W(RTN_W)) tbus ();

    tfe_down_count u_count (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus(tbus)
    );

    tfe_release_timer #(.RTN_W(RTN_W)) u_rtn (
        .hclk(hclk),
        .hresetn(hresetn),
        .bus(tbus)
    );

    logic irq_en_ff;
    logic flag_ff;
    tfe_mode_e mode_ff;
    logic run_ff;
    logic [1:0] sel_ff;
    logic [7:0] preset_ff;
    logic preset_wr_ff;
    logic [ISTAT_W-1:0] istat_ff;
    logic [ISTAT_W-1:0] imask_ff;
    logic [ISTAT_W-1:0] nxt_istat;
    logic wr_pend_ff;
    logic [31:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic oe_n_ff;
    logic irq_ff;
    logic pin_s1_ff;
    logic pin_s2_ff;
    logic addr_ok;
    logic rd_go;
    logic wr_go;
    logic wr_ctrl;
    logic clr_req;
    logic rd_istat;
    logic nxt_pull;

    function automatic logic [RTN_W-1:0] rtn_pick(input logic [1:0] sel,
                                                 input logic [7:0] pre);
        int c;
        unique case (sel)
            2'h0: c = (pre == 8'h01) ? RTN_SHORT_CYC : RTN_TICK_CYC;
            2'h1: c = (pre == 8'h01) ? RTN_MID_CYC : RTN_LONG_CYC;
            2'h2, 2'h3: c = RTN_LONG_CYC;
        endcase
        return c[RTN_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: reads answer in the data phase, writes add one wait
    assign addr_ok = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
    assign rd_go = addr_ok && !hwrite;
    assign wr_go = wr_pend_ff && tfe_reg_hit(wr_addr_ff);
    assign wr_ctrl = wr_go && (tfe_reg_idx(wr_addr_ff) == IDX_CTRL);
    assign clr_req = wr_ctrl && !hwdata[CTRL_FLAG_BIT];
    assign rd_istat = rd_go && tfe_reg_hit(haddr) &&
                      (tfe_reg_idx(haddr) == IDX_ISTAT);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 32'h00000000;
            hreadyout_ff <= 1'b1;
        end else begin
            wr_pend_ff <= addr_ok && hwrite;
            hreadyout_ff <= !(addr_ok && hwrite);
            if (addr_ok && hwrite) begin
                wr_addr_ff <= haddr;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h00000000;
        end else if (rd_go) begin
            hrdata_ff <= 32'h00000000;
            if (tfe_reg_hit(haddr)) begin
                unique case (tfe_reg_idx(haddr))
                    IDX_CTRL: begin
                        hrdata_ff[CTRL_IRQ_EN_BIT] <= irq_en_ff;
                        hrdata_ff[CTRL_FLAG_BIT] <= flag_ff;
                        hrdata_ff[CTRL_MODE_BIT] <= (mode_ff == TFE_REPEAT);
                        hrdata_ff[CTRL_PIN_BIT] <= pin_s2_ff;
                    end
                    IDX_TCTRL: begin
                        hrdata_ff[TCTRL_RUN_BIT] <= run_ff;
                        hrdata_ff[1:0] <= sel_ff;
                    end
                    IDX_PRESET: hrdata_ff[7:0] <= tbus.count;
                    IDX_ISTAT: hrdata_ff[ISTAT_W-1:0] <= istat_ff;
                    IDX_IMASK: hrdata_ff[ISTAT_W-1:0] <= imask_ff;
                    default: hrdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_en_ff <= 1'b0;
            mode_ff <= TFE_LEVEL;
        end else if (wr_ctrl) begin
            irq_en_ff <= hwdata[CTRL_IRQ_EN_BIT];
            mode_ff <= hwdata[CTRL_MODE_BIT] ? TFE_REPEAT : TFE_LEVEL;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_ff <= 1'b0;
            sel_ff <= SEL_RST;
        end else if (wr_go && tfe_reg_idx(wr_addr_ff) == IDX_TCTRL) begin
            run_ff <= hwdata[TCTRL_RUN_BIT];
            sel_ff <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            preset_ff <= PRESET_RST;
            preset_wr_ff <= 1'b0;
        end else begin
            preset_wr_ff <= wr_go && tfe_reg_idx(wr_addr_ff) == IDX_PRESET;
            if (wr_go && tfe_reg_idx(wr_addr_ff) == IDX_PRESET) begin
                preset_ff <= hwdata[7:0];
            end
        end
    end

    // Event wins over a clear in the same cycle; writing one is ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= 1'b0;
        end else if (tbus.event_p) begin
            flag_ff <= 1'b1;
        end else if (clr_req) begin
            flag_ff <= 1'b0;
        end
    end

    assign tbus.run = run_ff;
    assign tbus.sel = sel_ff;
    assign tbus.preset = preset_ff;
    assign tbus.preset_wr = preset_wr_ff;
    assign tbus.tick = src_tick;
    assign tbus.rtn_start = tbus.event_p && irq_en_ff &&
                            (mode_ff == TFE_REPEAT);
    assign tbus.rtn_len = rtn_pick(sel_ff, preset_ff);

    ////////////////////////////////////////////////////////////////////////
    // Open-drain pin: enable low means the pin is pulled low
    always_comb begin
        if (mode_ff == TFE_LEVEL) begin
            nxt_pull = irq_en_ff && flag_ff;
        end else begin
            nxt_pull = irq_en_ff && tbus.rtn_busy;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oe_n_ff <= 1'b1;
        end else begin
            oe_n_ff <= !nxt_pull;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_ff <= 1'b1;
            pin_s2_ff <= 1'b1;
        end else begin
            pin_s1_ff <= tirq_pin_i;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, cleared by read, gated by mask onto irq
    always_comb begin
        nxt_istat = rd_istat ? '0 : istat_ff;
        nxt_istat[ISTAT_EVENT_BIT] = nxt_istat[ISTAT_EVENT_BIT] |
                                     tbus.event_p;
        nxt_istat[ISTAT_RELEASE_BIT] = nxt_istat[ISTAT_RELEASE_BIT] |
                                       tbus.rtn_done;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_ff <= '0;
            imask_ff <= IMASK_RST;
            irq_ff <= 1'b0;
        end else begin
            istat_ff <= nxt_istat;
            irq_ff <= |(nxt_istat & imask_ff);
            if (wr_go && tfe_reg_idx(wr_addr_ff) == IDX_IMASK) begin
                imask_ff <= hwdata[ISTAT_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tirq_o <= 1'b0;
        end else begin
            tirq_o <= 1'b0;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign tirq_oe_n = oe_n_ff;
    assign irq = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_flag_set: assert property (tbus.event_p |=> flag_ff)
        else $error("flag not set by event");
    a_flag_hold: assert property (flag_ff && !clr_req |=> flag_ff)
        else $error("flag lost without clear");
    a_flag_clear: assert property (
        clr_req && !tbus.event_p |=> !flag_ff)
        else $error("flag not cleared by zero write");
    a_one_write: assert property (
        wr_ctrl && hwdata[CTRL_FLAG_BIT] && !flag_ff && !tbus.event_p
        |=> !flag_ff)
        else $error("write of one changed flag");
    a_count_keeps: assert property (
        clr_req && run_ff && src_tick[sel_ff] && tbus.count > 8'h01
        |=> tbus.count == $past(tbus.count) - 8'h01)
        else $error("flag clear disturbed countdown");
    a_level_free: assert property (
        mode_ff == TFE_LEVEL && !flag_ff |=> tirq_oe_n)
        else $error("level mode pin held after flag clear");
    a_level_again: assert property (
        tbus.event_p && run_ff && irq_en_ff && mode_ff == TFE_LEVEL
        ##1 irq_en_ff && mode_ff == TFE_LEVEL |=> !tirq_oe_n)
        else $error("level mode rearm failed");
    a_repeat_pull: assert property (
        tbus.event_p && irq_en_ff && mode_ff == TFE_REPEAT
        ##1 irq_en_ff |=> !tirq_oe_n)
        else $error("event did not pull pin");
    a_disabled_free: assert property (!irq_en_ff |=> tirq_oe_n)
        else $error("pin pulled while disabled");
    a_enable_drop: assert property ($fell(irq_en_ff) |=> tirq_oe_n)
        else $error("pin not freed on enable clear");
    a_enable_rise: assert property (
        $rose(irq_en_ff) && flag_ff && mode_ff == TFE_LEVEL |=> !tirq_oe_n)
        else $error("pin not pulled on enable rise");
    a_mode_hold: assert property (
        mode_ff == TFE_REPEAT && !tbus.rtn_busy |=> tirq_oe_n)
        else $error("repeated mode pin held after hold time");
    a_repeat_free: assert property (
        $fell(tbus.rtn_busy) && mode_ff == TFE_REPEAT |=> tirq_oe_n)
        else $error("pin not freed after hold time");
    a_stop_count: assert property (
        !run_ff && !preset_wr_ff |=> $stable(tbus.count) && !tbus.event_p)
        else $error("count moved while stopped");
    a_pull_cause: assert property (
        !tirq_oe_n |-> $past(irq_en_ff) && !tirq_o)
        else $error("pin pulled without enable");

    c_level_event: cover property (
        tbus.event_p && mode_ff == TFE_LEVEL && irq_en_ff);
    c_repeat_free: cover property (
        $fell(tbus.rtn_busy) && mode_ff == TFE_REPEAT);
    c_flag_cleared: cover property (flag_ff && clr_req);
    c_irq_raised: cover property ($rose(irq));
endmodule // tfe_timer_irq

/* tfe_host_model.sv */
// Host side of the open-drain timer interrupt line with its pull-up
`timescale 1ns/1ps
module tfe_host_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tirq_o,
    input wire logic tirq_oe_n,
    output logic pin_level,
    output logic [7:0] fall_cnt,
    output logic [15:0] low_len
);
    logic prev_ff;
    logic [15:0] run_ff;
    logic [7:0] nxt_fall;

    ////////////////////////////////////////////////////////////////////////
    // Wire level: pull-up wins whenever the device lets go
    assign pin_level = (tirq_oe_n === 1'b0) ? tirq_o : 1'b1;
    assign nxt_fall = fall_cnt + 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // Count falling edges and length of the last low stretch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_ff <= 1'b1;
            fall_cnt <= 8'h00;
            run_ff <= 16'h0000;
            low_len <= 16'h0000;
        end else begin
            prev_ff <= pin_level;
            if (prev_ff && !pin_level) begin
                fall_cnt <= nxt_fall;
            end
            if (!pin_level) begin
                run_ff <= run_ff + 16'h0001;
            end else begin
                run_ff <= 16'h0000;
            end
            if (!prev_ff && pin_level) begin
                low_len <= run_ff;
            end
        end
    end
endmodule // tfe_host_model

/* tb_timer_irq_flag_enable.sv */
// Self-checking bench for the timer flag and interrupt release block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_timer_irq_flag_enable
    import tfe_pkg::*;
;
    localparam logic [31:0] A_CTRL = {22'h000000, IDX_CTRL, 2'h0};
    localparam logic [31:0] A_TCTRL = {22'h000000, IDX_TCTRL, 2'h0};
    localparam logic [31:0] A_PRE = {22'h000000, IDX_PRESET, 2'h0};
    localparam logic [31:0] A_ISTAT = {22'h000000, IDX_ISTAT, 2'h0};
    localparam logic [31:0] A_IMASK = {22'h000000, IDX_IMASK, 2'h0};
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] src_tick;
    logic tirq_o, tirq_oe_n, irq, pin_level;
    logic [7:0] fall_cnt;
    logic [15:0] low_len;
    int mismatches = 0;
    int checks = 0;
    logic [1:0] sel_tb [5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
    logic [7:0] pre_tb [5] = '{8'h01, 8'h03, 8'h01, 8'h02, 8'h01};
    logic [15:0] hold_tb [5] = '{16'd5, 16'd8, 16'd12, 16'd16, 16'd16};

    assign hready = hreadyout;

    tfe_timer_irq #(.RTN_SHORT_CYC(5), .RTN_TICK_CYC(8), .RTN_MID_CYC(12),
        .RTN_LONG_CYC(16)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .src_tick(src_tick),
        .tirq_pin_i(pin_level), .tirq_o(tirq_o), .tirq_oe_n(tirq_oe_n),
        .irq(irq));

    tfe_host_model host (.hclk(hclk), .hresetn(hresetn), .tirq_o(tirq_o),
        .tirq_oe_n(tirq_oe_n), .pin_level(pin_level), .fall_cnt(fall_cnt),
        .low_len(low_len));

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        hclk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) hclk = ~hclk;
    end

    initial begin
        #300000;
        mismatches++;
        $display("watchdog expired");
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus and stimulus tasks
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, a, d, dummy);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h00000000, rd);
        `CHK(rd, e)
    endtask

    task automatic tick(input logic [1:0] s);
        @(posedge hclk);
        src_tick <= 4'h1 << s;
        @(posedge hclk);
        src_tick <= 4'h0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h00000000;
        src_tick = 4'h0;
        idle(4);
        hresetn <= 1'b1;
        // Reset values and an unmapped place
        `CHK(tirq_oe_n, 1'b1)
        `CHK(tirq_o, 1'b0)
        `CHK(irq, 1'b0)
        rchk(A_CTRL, 32'h00000100);
        rchk(A_TCTRL, 32'h00000000);
        rchk(A_PRE, 32'h00000000);
        rchk(A_IMASK, 32'h00000000);
        rchk(32'h00000080, 32'h00000000);
        `CHK(hresp, 1'b0)
        $display("test reset done");
        // Level mode event with enable set
        wr(A_PRE, 32'h00000002);
        wr(A_IMASK, 32'h00000001);
        wr(A_CTRL, 32'h00000001);
        wr(A_TCTRL, 32'h00000080);
        tick(2'h0);
        tick(2'h0);
        idle(4);
        rchk(A_CTRL, 32'h00000005);
        `CHK(tirq_oe_n, 1'b0)
        `CHK(irq, 1'b1)
        `CHK(fall_cnt, 8'h01)
        wr(A_CTRL, 32'h00000005);
        rchk(A_CTRL, 32'h00000005);
        wr(A_CTRL, 32'h00000004);
        idle(4);
        `CHK(tirq_oe_n, 1'b1)
        rchk(A_CTRL, 32'h00000104);
        wr(A_CTRL, 32'h00000005);
        idle(4);
        `CHK(tirq_oe_n, 1'b0)
        rchk(A_ISTAT, 32'h00000001);
        rchk(A_ISTAT, 32'h00000000);
        `CHK(irq, 1'b0)
        // Tick lands in the data phase of the flag clear
        fork
            wr(A_CTRL, 32'h00000001);
            begin
                @(posedge hclk);
                tick(2'h0);
            end
        join
        idle(4);
        `CHK(tirq_oe_n, 1'b1)
        rchk(A_CTRL, 32'h00000101);
        idle(2);
        rchk(A_PRE, 32'h00000001);
        tick(2'h0);
        idle(4);
        `CHK(tirq_oe_n, 1'b0)
        rchk(A_CTRL, 32'h00000005);
        `CHK(fall_cnt, 8'h03)
        $display("test level done");
        // Enable cleared: event sets flag, pin stays free
        wr(A_CTRL, 32'h00000000);
        tick(2'h0);
        tick(2'h0);
        idle(4);
        rchk(A_CTRL, 32'h00000104);
        `CHK(fall_cnt, 8'h03)
        `CHK(irq, 1'b1)
        wr(A_IMASK, 32'h00000000);
        idle(2);
        `CHK(irq, 1'b0)
        rchk(A_ISTAT, 32'h00000001);
        rchk(A_ISTAT, 32'h00000000);
        $display("test disabled done");
        // Repeated mode: hold time per source and preset
        for (int i = 0; i < 5; i++) begin
            wr(A_TCTRL, {30'h0, sel_tb[i]});
            wr(A_PRE, {24'h000000, pre_tb[i]});
            wr(A_CTRL, 32'h00000011);
            rchk(A_ISTAT, 32'h00000000);
            tick(sel_tb[i]);
            idle(2);
            rchk(A_PRE, {24'h000000, pre_tb[i]});
            wr(A_TCTRL, {24'h000000, 1'b1, 5'h00, sel_tb[i]});
            for (int k = 0; k < pre_tb[i]; k++) begin
                tick(sel_tb[i]);
            end
            idle(40);
            `CHK(fall_cnt, 8'h04 + 8'(i))
            `CHK(low_len >= hold_tb[i] && low_len <= hold_tb[i] + 1, 1'b1)
            `CHK(tirq_oe_n, 1'b1)
            rchk(A_ISTAT, 32'h00000003);
            rchk(A_CTRL, 32'h00000115);
        end
        $display("test repeated done");
        results();
    end
endmodule // tb_timer_irq_flag_enable
